/* rtl/ttd_pkg.sv */
/*
  Constants for the synchronous TFT panel timing generator: register byte
  offsets, field positions, reset values and bus widths.
  Assumes a 32-bit APB register bus and a single 25 MHz clock.
*/
`default_nettype none

package ttd_pkg;

  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned PIX_W          = 24;
  localparam int unsigned PIN_N          = 7;
  localparam int unsigned SEL_W          = 2;

  // register byte offsets
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_CLK        = 8'h04;
  localparam logic [7:0]  OFS_HTIME      = 8'h08;
  localparam logic [7:0]  OFS_HPOS       = 8'h0C;
  localparam logic [7:0]  OFS_VTIME      = 8'h10;
  localparam logic [7:0]  OFS_VPOS       = 8'h14;
  localparam logic [7:0]  OFS_OFFS       = 8'h18;
  localparam logic [7:0]  OFS_STROBE     = 8'h1C;
  localparam logic [7:0]  OFS_STATUS     = 8'h20;

  // control register fields
  localparam int unsigned CTRL_EN        = 0;
  localparam int unsigned CTRL_CLK_INV   = 1;
  localparam int unsigned CTRL_HS_LOW    = 2;
  localparam int unsigned CTRL_VS_LOW    = 3;
  localparam int unsigned CTRL_DE_LOW    = 4;
  localparam int unsigned CTRL_COMP_LSB  = 8;
  // clock register fields
  localparam int unsigned CLK_PER_LSB    = 0;
  localparam int unsigned CLK_OFF_LSB    = 16;
  localparam int unsigned CLK_UP_LSB     = 24;
  // generic 16-bit halves
  localparam int unsigned LO_LSB         = 0;
  localparam int unsigned HI_LSB         = 16;
  // strobe register fields
  localparam int unsigned DE_DLY_LSB     = 0;
  localparam int unsigned PIN_SEL_LSB    = 8;

  // pin source selections
  localparam logic [1:0]  SEL_LINE       = 2'h0;
  localparam logic [1:0]  SEL_FRAME      = 2'h1;
  localparam logic [1:0]  SEL_STROBE     = 2'h2;
  localparam logic [1:0]  SEL_WINDOW     = 2'h3;

  // period is in sixteenths of a base clock; one base clock is two half steps
  localparam logic [12:0] FRAC_ONE       = 13'h0010;
  localparam int unsigned HALF_PER_BASE  = 2;

  // reset values
  localparam logic [3:0]  RST_COMPS      = 4'h1;
  localparam logic [11:0] RST_CLK_PER    = 12'h020;
  localparam logic [7:0]  RST_CLK_OFF    = 8'h00;
  localparam logic [7:0]  RST_CLK_UP     = 8'h02;
  localparam logic [15:0] RST_LINE_LEN   = 16'h0030;
  localparam logic [15:0] RST_HS_W       = 16'h0008;
  localparam logic [15:0] RST_HBLANK     = 16'h0008;
  localparam logic [15:0] RST_HWIDTH     = 16'h0020;
  localparam logic [15:0] RST_FRAME_LEN  = 16'h0010;
  localparam logic [15:0] RST_VS_W       = 16'h00C0;
  localparam logic [15:0] RST_VBLANK     = 16'h0002;
  localparam logic [15:0] RST_VHEIGHT    = 16'h000C;
  localparam logic [15:0] RST_HS_OFF     = 16'h0000;
  localparam logic [15:0] RST_VS_OFF     = 16'h0000;
  localparam logic [7:0]  RST_DE_DLY     = 8'h00;
  // pin 0 carries line sync, pin 3 frame sync, pin 15 style strobe on pin 4
  localparam logic [13:0] RST_PIN_SEL    = 14'h3E64;

endpackage : ttd_pkg

`default_nettype wire

/* rtl/ttd_timing_gen.sv */
/*
  Synchronous TFT panel timing generator with APB register access.
  Assumes one clock, synchronous active-high reset, pixel source that
  presents the next pixel on pixel_in and takes it on pixel_take_out.
*/
// The implementer's own choices: the APB register port and the placing of the registers.
`default_nettype none

// Behaviour
// - panel clock, syncs, strobe and pixel bus
// - controls placed from local start points
// - accesses last whole base clocks
// - pixel data changes at start point
// - pixel bus is output only
// - falling-edge capture, clock runs continuously
// - line sync starts a new line
// - frame sync spans one full line sync; here a frame start point ends it sooner
// - strobe marks valid pixel data
// - clock and sync polarities selectable
// - pixel is components times panel clock
// - line period counted in panel clocks; here line_len counts pixels
// - line sync width in half steps
// - front blank then active width
// - rear blank fills rest of line
// - frame period counted in lines
// - frame sync width in half steps
// - front, active, rear vertical lines
// - panel clock edge offset, half steps
// - frame sync offset in half steps
// - line sync offset in half steps
// - strobe offset from data start point
// - seven assignable synchronous outputs
// - clock period in sixteenth base clocks
module ttd_timing_gen (
  input  wire logic                          ref_clk_in,
  input  wire logic                          srst_in,
  input  wire logic                          psel_in,
  input  wire logic                          penable_in,
  input  wire logic                          pwrite_in,
  input  wire logic [ttd_pkg::ADDR_W-1:0]    paddr_in,
  input  wire logic [ttd_pkg::DATA_W-1:0]    pwdata_in,
  output logic      [ttd_pkg::DATA_W-1:0]    prdata_out,
  output logic                               pready_out,
  output logic                               pslverr_out,
  input  wire logic [ttd_pkg::PIX_W-1:0]     pixel_in,
  output logic                               pixel_take_out,
  output logic                               panel_clk_out,
  output logic                               line_sync_out,
  output logic                               frame_sync_out,
  output logic                               data_valid_strobe_out,
  output logic      [ttd_pkg::PIX_W-1:0]     pixel_data_out,
  output logic      [ttd_pkg::PIN_N-1:0]     sync_pin_out
);
  import ttd_pkg::*;

  typedef struct packed {
    // software settings
    logic        enable;
    logic        clk_inv;
    logic        hs_low;
    logic        vs_low;
    logic        de_low;
    logic [3:0]  comps;
    logic [11:0] clk_period;
    logic [7:0]  clk_off;
    logic [7:0]  clk_up;
    logic [15:0] line_len;
    logic [15:0] hs_w;
    logic [15:0] front_horizontal_blank;
    logic [15:0] active_line_width;
    logic [15:0] frame_len;
    logic [15:0] vs_w;
    logic [15:0] front_vertical_blank;
    logic [15:0] active_frame_height;
    logic [15:0] hs_off;
    logic [15:0] vs_off;
    logic [7:0]  valid_strobe_delay;
    logic [13:0] pin_sel;
    // timing engine
    logic        base_ph;
    logic [12:0] acc;
    logic        started;
    logic [7:0]  acc_hs;
    logic [3:0]  comp;
    logic [15:0] h;
    logic [15:0] v;
    logic [15:0] line_hs;
    logic [23:0] frame_hs;
    logic        pclk;
    logic        hs;
    logic        vs;
    logic        vs_hs_began;
    logic        vs_hs_done;
    logic        de;
    logic        active;
    // pins and bus answer
    logic        o_pclk;
    logic        o_hs;
    logic        o_vs;
    logic        o_de;
    logic [6:0]  o_pins;
    logic [23:0] o_pix;
    logic        o_take;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ttd_state_s;

  ttd_state_s s;
  ttd_state_s next_s;

  logic [PIN_N-1:0] pin_val;

  ////////////////////////////////////////////////////////////////////////////
  // general synchronous outputs: each picks one of four periodic sources
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_pin
      always_comb begin
        unique case (s.pin_sel[gi*SEL_W +: SEL_W])
          SEL_LINE:   pin_val[gi] = next_s.o_hs;
          SEL_FRAME:  pin_val[gi] = next_s.o_vs;
          SEL_STROBE: pin_val[gi] = next_s.o_de;
          SEL_WINDOW: pin_val[gi] = next_s.active;
        endcase
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [12:0] acc_sum;
    logic [12:0] per;
    logic        tick;
    logic [7:0]  hs_n;
    logic [3:0]  comps_eff;
    logic        line_start;
    logic        frame_start;
    logic [16:0] hs_end;
    logic [16:0] vs_end;
    logic [8:0]  up_pt;
    logic        in_h;
    logic        in_v;
    logic        hs_prev;
    acc_sum     = '0;
    per         = '0;
    tick        = 1'b0;
    hs_n        = '0;
    comps_eff   = '0;
    line_start  = 1'b0;
    frame_start = 1'b0;
    hs_end      = '0;
    vs_end      = '0;
    up_pt       = '0;
    in_h        = 1'b0;
    in_v        = 1'b0;
    hs_prev     = s.hs;

    next_s         = s;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.o_take  = 1'b0;

    // apb: answer one cycle into the access phase, write lands on completion
    if (psel_in && penable_in && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.prdata = '0;
      unique case (paddr_in)
        OFS_CTRL: begin
          next_s.prdata[CTRL_EN]               = s.enable;
          next_s.prdata[CTRL_CLK_INV]          = s.clk_inv;
          next_s.prdata[CTRL_HS_LOW]           = s.hs_low;
          next_s.prdata[CTRL_VS_LOW]           = s.vs_low;
          next_s.prdata[CTRL_DE_LOW]           = s.de_low;
          next_s.prdata[CTRL_COMP_LSB +: 4]    = s.comps;
        end
        OFS_CLK: begin
          next_s.prdata[CLK_PER_LSB +: 12]     = s.clk_period;
          next_s.prdata[CLK_OFF_LSB +: 8]      = s.clk_off;
          next_s.prdata[CLK_UP_LSB +: 8]       = s.clk_up;
        end
        OFS_HTIME:  next_s.prdata = {s.hs_w, s.line_len};
        OFS_HPOS:   next_s.prdata = {s.active_line_width, s.front_horizontal_blank};
        OFS_VTIME:  next_s.prdata = {s.vs_w, s.frame_len};
        OFS_VPOS:   next_s.prdata = {s.active_frame_height, s.front_vertical_blank};
        OFS_OFFS:   next_s.prdata = {s.vs_off, s.hs_off};
        OFS_STROBE: begin
          next_s.prdata[DE_DLY_LSB +: 8]       = s.valid_strobe_delay;
          next_s.prdata[PIN_SEL_LSB +: 14]     = s.pin_sel;
        end
        OFS_STATUS: next_s.prdata = {s.v, s.h};
        default:    next_s.pslverr = 1'b1;
      endcase
    end
    if (psel_in && penable_in && s.pready && pwrite_in) begin
      unique case (paddr_in)
        OFS_CTRL: begin
          next_s.enable  = pwdata_in[CTRL_EN];
          next_s.clk_inv = pwdata_in[CTRL_CLK_INV];
          next_s.hs_low  = pwdata_in[CTRL_HS_LOW];
          next_s.vs_low  = pwdata_in[CTRL_VS_LOW];
          next_s.de_low  = pwdata_in[CTRL_DE_LOW];
          next_s.comps   = pwdata_in[CTRL_COMP_LSB +: 4];
        end
        OFS_CLK: begin
          next_s.clk_period = pwdata_in[CLK_PER_LSB +: 12];
          next_s.clk_off    = pwdata_in[CLK_OFF_LSB +: 8];
          next_s.clk_up     = pwdata_in[CLK_UP_LSB +: 8];
        end
        OFS_HTIME: begin
          next_s.line_len = pwdata_in[LO_LSB +: 16];
          next_s.hs_w     = pwdata_in[HI_LSB +: 16];
        end
        OFS_HPOS: begin
          next_s.front_horizontal_blank = pwdata_in[LO_LSB +: 16];
          next_s.active_line_width      = pwdata_in[HI_LSB +: 16];
        end
        OFS_VTIME: begin
          next_s.frame_len = pwdata_in[LO_LSB +: 16];
          next_s.vs_w      = pwdata_in[HI_LSB +: 16];
        end
        OFS_VPOS: begin
          next_s.front_vertical_blank = pwdata_in[LO_LSB +: 16];
          next_s.active_frame_height  = pwdata_in[HI_LSB +: 16];
        end
        OFS_OFFS: begin
          next_s.hs_off = pwdata_in[LO_LSB +: 16];
          next_s.vs_off = pwdata_in[HI_LSB +: 16];
        end
        OFS_STROBE: begin
          next_s.valid_strobe_delay = pwdata_in[DE_DLY_LSB +: 8];
          next_s.pin_sel            = pwdata_in[PIN_SEL_LSB +: 14];
        end
        default: ;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // timing engine; one base clock is two cycles, so a cycle is a half step
    if (!s.enable) begin
      next_s.base_ph     = 1'b0;
      next_s.acc         = '0;
      next_s.started     = 1'b0;
      next_s.acc_hs      = '0;
      next_s.comp        = '0;
      next_s.h           = '0;
      next_s.v           = '0;
      next_s.line_hs     = '0;
      next_s.frame_hs    = '0;
      next_s.pclk        = 1'b1;
      next_s.hs          = 1'b0;
      next_s.vs          = 1'b0;
      next_s.vs_hs_began = 1'b0;
      next_s.vs_hs_done  = 1'b0;
      next_s.de          = 1'b0;
      next_s.active      = 1'b0;
    end else begin
      next_s.base_ph = ~s.base_ph;
      // period below one base clock is treated as one base clock
      per = (s.clk_period < FRAC_ONE[11:0]) ? FRAC_ONE : {1'b0, s.clk_period};
      // access starts only on a base clock boundary: whole base clocks long
      if (!s.base_ph) begin
        acc_sum = s.acc + FRAC_ONE;
        if (acc_sum >= per || !s.started) begin
          tick       = 1'b1;
          next_s.acc = s.started ? 13'(acc_sum - per) : '0;
        end else begin
          next_s.acc = acc_sum;
        end
      end

      // position counters advance on each local start point
      comps_eff = (s.comps == 4'h0) ? 4'h1 : s.comps;
      if (tick) begin
        next_s.started = 1'b1;
        if (s.started) begin
          if (s.comp >= 4'(comps_eff - 4'h1)) begin
            next_s.comp = '0;
            if (s.h >= 16'(s.line_len - 16'h0001)) begin
              next_s.h = '0;
              next_s.v = (s.v >= 16'(s.frame_len - 16'h0001)) ? '0
                                                               : 16'(s.v + 16'h0001);
            end else begin
              next_s.h = 16'(s.h + 16'h0001);
            end
          end else begin
            next_s.comp = 4'(s.comp + 4'h1);
          end
        end
        line_start  = (next_s.h == 16'h0000) && (next_s.comp == 4'h0);
        frame_start = line_start && (next_s.v == 16'h0000);
      end

      // half steps since the access, line and frame start points
      hs_n               = tick ? 8'h00 : ((s.acc_hs == 8'hFF) ? s.acc_hs : 8'(s.acc_hs + 8'h01));
      next_s.acc_hs      = hs_n;
      next_s.line_hs     = line_start ? 16'h0000 :
                           ((s.line_hs == 16'hFFFF) ? s.line_hs : 16'(s.line_hs + 16'h0001));
      next_s.frame_hs    = frame_start ? 24'h000000 :
                           ((s.frame_hs == 24'hFFFFFF) ? s.frame_hs
                                                       : 24'(s.frame_hs + 24'h000001));

      // panel clock falls at its offset and rises clk_up half steps later
      up_pt = {1'b0, s.clk_off} + {1'b0, s.clk_up};
      if (hs_n == s.clk_off) begin
        next_s.pclk = 1'b0;
      end else if ({1'b0, hs_n} == up_pt) begin
        next_s.pclk = 1'b1;
      end

      // line sync window measured from the line start point
      hs_end    = {1'b0, s.hs_off} + {1'b0, s.hs_w};
      next_s.hs = (next_s.line_hs >= s.hs_off) && ({1'b0, next_s.line_hs} < hs_end);

      // frame sync: offset and width, but only a frame start point ends it before a line sync has
      // both begun and finished inside it, so the panel sees one unless the frame ends first
      vs_end = {1'b0, s.vs_off} + {1'b0, s.vs_w};
      if (frame_start) begin
        next_s.vs          = 1'b0;
        next_s.vs_hs_began = 1'b0;
        next_s.vs_hs_done  = 1'b0;
      end
      if (!s.vs && (s.frame_hs[23:16] == 8'h00) && (next_s.frame_hs[15:0] == s.vs_off)
          && !(frame_start && s.vs_off != 16'h0000)) begin
        next_s.vs          = 1'b1;
        next_s.vs_hs_began = next_s.hs && !hs_prev;
        next_s.vs_hs_done  = 1'b0;
      end else if (s.vs) begin
        if (next_s.hs && !hs_prev) begin
          next_s.vs_hs_began = 1'b1;
        end
        if (!next_s.hs && hs_prev && s.vs_hs_began) begin
          next_s.vs_hs_done = 1'b1;
        end
        if ((next_s.frame_hs >= {7'h00, vs_end}) && next_s.vs_hs_done) begin
          next_s.vs = 1'b0;
        end
      end

      // active window: front blank, then active width; rear blank is the rest
      in_h = (s.h >= s.front_horizontal_blank) &&
             ({1'b0, s.h} < ({1'b0, s.front_horizontal_blank} +
                             {1'b0, s.active_line_width}));
      in_v = (s.v >= s.front_vertical_blank) &&
             ({1'b0, s.v} < ({1'b0, s.front_vertical_blank} +
                             {1'b0, s.active_frame_height}));
      if (tick) begin
        next_s.active = in_h && in_v && next_s.started && s.started;
        // data moves only at the start point; its position is not adjustable
        if (next_s.active) begin
          next_s.o_pix  = pixel_in;
          next_s.o_take = 1'b1;
        end
      end
      // strobe edges follow the start point of their data by the delay
      if (hs_n == s.valid_strobe_delay) begin
        next_s.de = next_s.active;
      end
    end

    // pin levels with polarity applied
    next_s.o_pclk = next_s.pclk ^ s.clk_inv;
    next_s.o_hs   = next_s.hs ^ s.hs_low;
    next_s.o_vs   = next_s.vs ^ s.vs_low;
    next_s.o_de   = next_s.de ^ s.de_low;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      s                        <= '0;
      s.comps                  <= RST_COMPS;
      s.clk_period             <= RST_CLK_PER;
      s.clk_off                <= RST_CLK_OFF;
      s.clk_up                 <= RST_CLK_UP;
      s.line_len               <= RST_LINE_LEN;
      s.hs_w                   <= RST_HS_W;
      s.front_horizontal_blank <= RST_HBLANK;
      s.active_line_width      <= RST_HWIDTH;
      s.frame_len              <= RST_FRAME_LEN;
      s.vs_w                   <= RST_VS_W;
      s.front_vertical_blank   <= RST_VBLANK;
      s.active_frame_height    <= RST_VHEIGHT;
      s.hs_off                 <= RST_HS_OFF;
      s.vs_off                 <= RST_VS_OFF;
      s.valid_strobe_delay     <= RST_DE_DLY;
      s.pin_sel                <= RST_PIN_SEL;
      s.pclk                   <= 1'b1;
      s.o_pclk                 <= 1'b1;
    end else begin
      s        <= next_s;
      s.o_pins <= pin_val;
    end
  end

  // every pin comes straight from the state register; the pixel bus has no
  // input path at all
  assign prdata_out            = s.prdata;
  assign pready_out            = s.pready;
  assign pslverr_out           = s.pslverr;
  assign pixel_take_out        = s.o_take;
  assign panel_clk_out         = s.o_pclk;
  assign line_sync_out         = s.o_hs;
  assign frame_sync_out        = s.o_vs;
  assign data_valid_strobe_out = s.o_de;
  assign pixel_data_out        = s.o_pix;
  assign sync_pin_out          = s.o_pins;

endmodule : ttd_timing_gen

`default_nettype wire

/* verif/ttd_monitor.sv */
/* Port checker for ttd_timing_gen.
   Assumes it is bound to the top module and sees only its ports. */
`default_nettype none
module ttd_monitor (
  input wire logic                       ref_clk_in,
  input wire logic                       srst_in,
  input wire logic                       psel_in,
  input wire logic                       penable_in,
  input wire logic                       pready_out,
  input wire logic                       pslverr_out,
  input wire logic [ttd_pkg::DATA_W-1:0] prdata_out,
  input wire logic                       pixel_take_out,
  input wire logic [ttd_pkg::PIX_W-1:0]  pixel_data_out,
  input wire logic                       panel_clk_out,
  input wire logic                       line_sync_out,
  input wire logic                       frame_sync_out
);
  import ttd_pkg::*;
  logic       par;
  logic       seen;
  logic       ls_began;
  logic       ls_full;
  logic [3:0] idle;
  ////////////////////////////////////////
  // idle level flips after a polarity change are not pulses, so a stopped clock clears seen
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      par      <= 1'b0;
      seen     <= 1'b0;
      ls_began <= 1'b0;
      ls_full  <= 1'b0;
      idle     <= 4'h0;
    end else begin
      par  <= $rose(line_sync_out) ? 1'b1 : !par;
      seen <= idle[3] ? 1'b0 : (seen || $rose(line_sync_out));
      idle <= $changed(panel_clk_out) ? 4'h0 : ((idle == 4'hF) ? idle : idle + 4'h1);
      if ($rose(frame_sync_out)) begin
        ls_began <= $rose(line_sync_out);
        ls_full  <= 1'b0;
      end else begin
        ls_began <= ls_began || $rose(line_sync_out);
        ls_full  <= ls_full || (ls_began && $fell(line_sync_out));
      end
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  chk_apb_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("ready missing after one wait state");
  chk_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");
  chk_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("error flag without ready");
  chk_rdata_only_answer: assert property ($changed(prdata_out) |-> pready_out)
    else $error("read data moved outside an answer");
  chk_data_at_start: assert property ($changed(pixel_data_out) |-> pixel_take_out)
    else $error("pixel bus moved away from a start point");
  chk_clock_keeps_running: assert property ($changed(line_sync_out) |-> ##[0:64] $changed(panel_clk_out))
    else $error("panel clock still while line sync moves");
  chk_line_whole_base: assert property ($rose(line_sync_out) && seen |-> !par)
    else $error("line period not whole base clocks");
  chk_frame_spans_line: assert property ($fell(frame_sync_out) |-> ls_full || (ls_began && $fell(line_sync_out)))
    else $error("frame sync ended without a full line sync");
  cov_frame_end: cover property ($fell(frame_sync_out));
  cov_bus_error: cover property (pslverr_out);
  cov_pixel_take: cover property (pixel_take_out);
endmodule : ttd_monitor

bind ttd_timing_gen ttd_monitor u_mon (
  .ref_clk_in(ref_clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .prdata_out(prdata_out),
  .pixel_take_out(pixel_take_out), .pixel_data_out(pixel_data_out),
  .panel_clk_out(panel_clk_out), .line_sync_out(line_sync_out),
  .frame_sync_out(frame_sync_out));
`default_nettype wire

/* verif/ttd_panel_model.sv */
/* Behavioural TFT panel: counts components shifted in.
   Assumes positive clock polarity and an active-high strobe. */
`default_nettype none
module ttd_panel_model (
  input  wire logic panel_clk_in,
  input  wire logic strobe_in,
  input  wire logic clear_in,
  output var  int   cap_count_out
);
  initial cap_count_out = 0;
  // capture on the falling panel clock edge, only while the strobe marks valid data
  always @(negedge panel_clk_in or posedge clear_in) begin
    if (clear_in) cap_count_out = 0;
    else if (strobe_in === 1'b1) cap_count_out = cap_count_out + 1;
  end
endmodule : ttd_panel_model
`default_nettype wire

/* verif/tb_tft_sync_display_timing.sv */
/* Self-checking bench for ttd_timing_gen: APB master, pixel source, panel model.
   Assumes the monitor is bound by its own file. */
`default_nettype none
module tb_tft_sync_display_timing;
  timeunit 1ns;
  timeprecision 1ns;
  import ttd_pkg::*;
  localparam int MAX_CYC = 20000;
  logic              clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, clr = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata;
  logic [PIX_W-1:0]  pix = '0, pdata;
  logic              pready, pslverr, take, pclk, ls, fs, dvs;
  logic [PIN_N-1:0]  spin;
  int                failures = 0, cmp_count = 0, cyc = 0, caps;
  ////////////////////////////////////////
  ttd_timing_gen dut (.ref_clk_in(clk), .srst_in(srst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .pixel_in(pix), .pixel_take_out(take),
    .panel_clk_out(pclk), .line_sync_out(ls), .frame_sync_out(fs),
    .data_valid_strobe_out(dvs), .pixel_data_out(pdata), .sync_pin_out(spin));
  ttd_panel_model u_panel (.panel_clk_in(pclk), .strobe_in(dvs), .clear_in(clr),
    .cap_count_out(caps));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (take === 1'b1) pix <= pix + 24'h000001;
    if (clr) clr <= 1'b0;
    if (cyc == MAX_CYC) final_report(1'b1);
  end
  ////////////////////////////////////////
  task automatic final_report(input bit tmo);
    if (tmo) failures++;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1; pwr <= wr; paddr <= a; pwdata <= d; pen <= 1'b0;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic do_reset(input int n);
    srst <= 1'b1;
    repeat (n) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask : do_reset
  function automatic logic sig(input int k);
    case (k)
      0: return pclk;
      1: return ls;
      default: return fs;
    endcase
  endfunction : sig
  task automatic rise(input int k);
    do @(posedge clk); while (sig(k) !== 1'b0);
    do @(posedge clk); while (sig(k) !== 1'b1);
  endtask : rise
  // starts at a rising sample, ends at the next one, so calls may follow each other
  task automatic measure(input int k, output int hi, output int per);
    hi = 1; per = 0;
    do begin @(posedge clk); per++; if (sig(k) === 1'b1) hi++; end while (sig(k) !== 1'b0);
    do begin @(posedge clk); per++; end while (sig(k) !== 1'b1);
  endtask : measure
  task automatic start(input logic [31:0] clkreg, input logic [31:0] ctrl);
    logic [31:0] d;
    logic        e;
    do_reset(4);
    apb(1'b1, OFS_CLK, clkreg, d, e);
    apb(1'b1, OFS_CTRL, ctrl, d, e);
  endtask : start
  ////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    logic        e;
    apb(1'b0, OFS_CLK, '0, d, e);
    check(d, {RST_CLK_UP, RST_CLK_OFF, 4'h0, RST_CLK_PER});
    apb(1'b0, OFS_HTIME, '0, d, e);
    check(d, {RST_HS_W, RST_LINE_LEN});
    apb(1'b0, OFS_VTIME, '0, d, e);
    check(d, {RST_VS_W, RST_FRAME_LEN});
    apb(1'b1, OFS_HPOS, 32'h0021_0009, d, e);
    apb(1'b0, OFS_HPOS, '0, d, e);
    check(d, 32'h0021_0009);
    apb(1'b0, 8'h24, '0, d, e);
    check({31'h0, e}, 32'h1);
    check(d, 32'h0);
  endtask : t_regs
  task automatic t_frame();
    int hi, per;
    start(32'h0201_0020, 32'h0000_0101);
    rise(0);
    measure(0, hi, per);
    check(per, 4);
    check(hi, 2);
    rise(1);
    measure(1, hi, per);
    check(per, 32'h30 * 4);
    check(hi, 8);
    rise(2);
    clr <= 1'b1;
    measure(2, hi, per);
    check(per, 32'h10 * 32'h30 * 4);
    check(hi >= 32'hC0, 1);
    check(caps, 32'h20 * 32'h0C);
  endtask : t_frame
  task automatic t_comps();
    int hi, per;
    start(32'h0201_0020, 32'h0000_0201);
    rise(1);
    measure(1, hi, per);
    check(per, 32'h30 * 2 * 4);
  endtask : t_comps
  task automatic t_clock();
    int hi, per, p2;
    start(32'h0301_0030, 32'h0000_0101);
    rise(0);
    measure(0, hi, per);
    check(per, 6);
    check(hi, 3);
    start(32'h0201_0028, 32'h0000_0101);
    rise(0);
    measure(0, hi, per);
    measure(0, hi, p2);
    check(per + p2, 10);
  endtask : t_clock
  task automatic t_polarity();
    start(32'h0201_0020, 32'h0000_001E);
    repeat (2) @(posedge clk);
    check({pclk, ls, fs, dvs}, 4'b0111);
    check(spin, 7'h1F);
  endtask : t_polarity
  ////////////////////////////////////////
  initial begin
    do_reset(16);
    t_regs();
    t_frame();
    t_comps();
    t_clock();
    t_polarity();
    final_report(1'b0);
  end
endmodule : tb_tft_sync_display_timing
`default_nettype wire
